// ### hdl/pbl_params.svh
/*
 * Constants for the PLL bandwidth and lock control block: register
 * offsets, field positions, reset values and timing counts.
 * Assumes a 20 MHz register clock and a byte-addressed APB slave.
 */
`ifndef PBL_PARAMS_SVH
`define PBL_PARAMS_SVH

// apb address map, byte addresses of aligned 32-bit words
`define PBL_ADDR_W 8
`define PBL_OFF_CTRL 8'h00
`define PBL_OFF_STAT 8'h04
`define PBL_OFF_EVT 8'h08
`define PBL_OFF_MASK 8'h0C

// control register fields
`define PBL_CTRL_W 5
`define PBL_CTRL_AUTO 0
`define PBL_CTRL_ACQ 1
`define PBL_CTRL_PON 2
`define PBL_CTRL_BCS 3
`define PBL_CTRL_IRQEN 4
`define PBL_CTRL_RST 5'h01

// status register fields
`define PBL_STAT_LOCK 0
`define PBL_STAT_TRACK 1
`define PBL_STAT_PON 2
`define PBL_STAT_BCS 3

// event and mask registers share one layout
`define PBL_EVT_W 2
`define PBL_EVT_LOCK_CHG 0
`define PBL_EVT_LOCK_LOSS 1
`define PBL_EVT_RST 2'h0
`define PBL_MASK_RST 2'h0

// tolerance detector qualification: least time, rounded up to cycles
`define PBL_CLK_PERIOD_NS 50
`define PBL_QUAL_TIME_NS 200
`define PBL_QUAL_CYC ((`PBL_QUAL_TIME_NS + `PBL_CLK_PERIOD_NS - 1) / `PBL_CLK_PERIOD_NS)
`define PBL_QUAL_CW 3

`endif

// ### hdl/pbl_pkg.sv
/*
 * Types for the PLL bandwidth and lock control block.
 * Assumes pbl_params.svh supplies the numeric constants.
 */
package pbl_pkg;

  // loop filter operating mode
  typedef enum logic {
    PBL_ACQUIRE = 1'b0,
    PBL_TRACK   = 1'b1
  } pbl_filt_t;

  // apb slave phase
  typedef enum logic [1:0] {
    PBL_BUS_IDLE   = 2'b00,
    PBL_BUS_ANSWER = 2'b01
  } pbl_bus_st_t;

endpackage

// ### hdl/pbl_tol_detect.sv
/*
 * Synchronises and qualifies the two VCO frequency tolerance
 * comparator outputs. Assumes the comparators are asynchronous
 * to mclk_i and may chatter near the window edges.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pbl_params.svh"

module pbl_tol_detect (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // raw comparator levels
  input wire logic [1:0] tol_raw_i,
  // qualified levels
  output logic [1:0] tol_ok_o
);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      logic meta_q;
      logic sync_q;
      logic ok_q;
      logic [`PBL_QUAL_CW-1:0] cnt_q;

      always_ff @(posedge mclk_i) begin
        if (rst_i) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= tol_raw_i[gi];
          sync_q <= meta_q;
        end
      end

      // a level is accepted only after it stays put, so chatter never toggles lock
      always_ff @(posedge mclk_i) begin
        if (rst_i) begin
          cnt_q <= '0;
          ok_q <= 1'b0;
        end else if (sync_q == ok_q) begin
          cnt_q <= '0;
        end else if (cnt_q == `PBL_QUAL_CW'(`PBL_QUAL_CYC - 1)) begin
          cnt_q <= '0;
          ok_q <= sync_q;
        end else begin
          cnt_q <= cnt_q + `PBL_QUAL_CW'(1);
        end
      end

      assign tol_ok_o[gi] = ok_q;
    end
  endgenerate

endmodule
`default_nettype wire

// ### hdl/pbl_top.sv
/*
 * PLL loop filter bandwidth and lock control with an APB register
 * file and one level interrupt. Assumes the analog PLL supplies two
 * asynchronous comparator levels: VCO inside the acquisition window
 * and VCO inside the lock window, and accepts the filter mode, power
 * and base clock select levels driven here.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pbl_params.svh"

// Function
// - With automatic bandwidth on and the PLL powered on, the lock detector moves the filter between acquire and track without software.
// - In automatic mode the acquire/track bit is read-only and shows the current filter mode.
// - In automatic mode with the PLL powered on, the acquire/track bit sets inside the VCO tolerance window and clears outside it.
// - In automatic mode the lock bit is read-only, set inside the lock tolerance while the PLL is powered on, and clear otherwise.
// - In automatic mode with the PLL interrupt enabled and the lock-change mask bit set, every toggle of the lock bit raises an interrupt.
// - With automatic bandwidth off, the acquire/track bit is a writable control: zero acquire, one track.
// - In manual mode the lock bit is disabled and no clock generator interrupt is raised.
module pbl_top (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [`PBL_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // analog pll comparators, asynchronous
  input wire logic vco_in_acq_tol_i,
  input wire logic vco_in_lock_tol_i,
  // pll controls
  output logic loop_filter_track_o,
  output logic pll_power_on_o,
  output logic base_clock_select_o,
  output logic lock_o,
  // interrupt
  output logic irq_o
);

  // control register
  logic auto_q;
  logic pll_power_on_q;
  logic base_clock_select_q;
  logic pll_irq_enable_q;
  pbl_pkg::pbl_filt_t filt_q;
  pbl_pkg::pbl_filt_t filt_d;

  // lock and events
  logic lock_q;
  logic lock_d;
  logic [`PBL_EVT_W-1:0] evt_q;
  logic [`PBL_EVT_W-1:0] evt_d;
  logic [`PBL_EVT_W-1:0] evt_set;
  logic [`PBL_EVT_W-1:0] evt_clr;
  logic [`PBL_EVT_W-1:0] mask_q;
  logic irq_q;

  // bus
  pbl_pkg::pbl_bus_st_t bus_st_q;
  logic [31:0] rdata_q;
  logic ready_q;
  logic slverr_q;
  logic [31:0] rd_mux;
  logic addr_hit;
  logic wr_commit;
  logic wr_ctrl;
  logic wr_evt;
  logic wr_mask;
  logic wr_acq;

  // qualified comparator levels
  logic [1:0] tol_ok;
  logic acq_ok;
  logic lock_ok;
  logic auto_run;

  // reset image of the control word, so each bit's reset value is named once
  localparam logic [`PBL_CTRL_W-1:0] ctrl_rst = `PBL_CTRL_RST;

  // bit 0 is the acquisition window, bit 1 the lock window
  pbl_tol_detect u_tol (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .tol_raw_i ({vco_in_lock_tol_i, vco_in_acq_tol_i}),
    .tol_ok_o  (tol_ok)
  );

  assign acq_ok = tol_ok[0];
  assign lock_ok = tol_ok[1];
  // the detector is meaningless with the vco powered down
  assign auto_run = auto_q & pll_power_on_q;

  // apb decode
  always_comb begin
    addr_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr_i)
      `PBL_OFF_CTRL: begin
        rd_mux[`PBL_CTRL_AUTO] = auto_q;
        rd_mux[`PBL_CTRL_ACQ] = filt_q;
        rd_mux[`PBL_CTRL_PON] = pll_power_on_q;
        rd_mux[`PBL_CTRL_BCS] = base_clock_select_q;
        rd_mux[`PBL_CTRL_IRQEN] = pll_irq_enable_q;
      end
      `PBL_OFF_STAT: begin
        rd_mux[`PBL_STAT_LOCK] = lock_q;
        rd_mux[`PBL_STAT_TRACK] = filt_q;
        rd_mux[`PBL_STAT_PON] = pll_power_on_q;
        rd_mux[`PBL_STAT_BCS] = base_clock_select_q;
      end
      `PBL_OFF_EVT: rd_mux[`PBL_EVT_W-1:0] = evt_q;
      `PBL_OFF_MASK: rd_mux[`PBL_EVT_W-1:0] = mask_q;
      default: addr_hit = 1'b0;
    endcase
  end

  assign wr_commit = (bus_st_q == pbl_pkg::PBL_BUS_ANSWER) & psel_i & penable_i & pwrite_i & addr_hit;
  assign wr_ctrl = wr_commit & (paddr_i == `PBL_OFF_CTRL);
  assign wr_evt = wr_commit & (paddr_i == `PBL_OFF_EVT);
  assign wr_mask = wr_commit & (paddr_i == `PBL_OFF_MASK);
  assign wr_acq = pwdata_i[`PBL_CTRL_ACQ];

  // apb phase: zero wait states, answer in the first access cycle
  // read data is the state at the setup edge; a write lands one edge later
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      bus_st_q <= pbl_pkg::PBL_BUS_IDLE;
      ready_q <= 1'b0;
      slverr_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      unique case (bus_st_q)
        pbl_pkg::PBL_BUS_IDLE: begin
          if (psel_i && !penable_i) begin
            bus_st_q <= pbl_pkg::PBL_BUS_ANSWER;
            ready_q <= 1'b1;
            slverr_q <= ~addr_hit;
            rdata_q <= pwrite_i ? 32'h0000_0000 : rd_mux;
          end
        end
        pbl_pkg::PBL_BUS_ANSWER: begin
          bus_st_q <= pbl_pkg::PBL_BUS_IDLE;
          ready_q <= 1'b0;
          slverr_q <= 1'b0;
          rdata_q <= 32'h0000_0000;
        end
        default: begin
          bus_st_q <= pbl_pkg::PBL_BUS_IDLE;
          ready_q <= 1'b0;
        end
      endcase
    end
  end

  // software controls
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      auto_q <= ctrl_rst[`PBL_CTRL_AUTO];
      pll_power_on_q <= ctrl_rst[`PBL_CTRL_PON];
      base_clock_select_q <= ctrl_rst[`PBL_CTRL_BCS];
      pll_irq_enable_q <= ctrl_rst[`PBL_CTRL_IRQEN];
    end else if (wr_ctrl) begin
      auto_q <= pwdata_i[`PBL_CTRL_AUTO];
      pll_power_on_q <= pwdata_i[`PBL_CTRL_PON];
      base_clock_select_q <= pwdata_i[`PBL_CTRL_BCS];
      pll_irq_enable_q <= pwdata_i[`PBL_CTRL_IRQEN];
    end
  end

  // filter mode: detector owns it in auto, software in manual
  always_comb begin
    filt_d = filt_q;
    if (auto_q) begin
      // writes to the select bit are ignored here
      filt_d = (auto_run && acq_ok) ? pbl_pkg::PBL_TRACK : pbl_pkg::PBL_ACQUIRE;
    end else if (wr_ctrl) begin
      filt_d = wr_acq ? pbl_pkg::PBL_TRACK : pbl_pkg::PBL_ACQUIRE;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      filt_q <= pbl_pkg::PBL_ACQUIRE;
    end else begin
      filt_q <= filt_d;
    end
  end

  // lock indicator, forced low when disabled in manual mode
  assign lock_d = auto_run & lock_ok;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      lock_q <= 1'b0;
    end else begin
      lock_q <= lock_d;
    end
  end

  // events: any lock toggle in automatic mode, and lock lost while the vco drives the base clock
  always_comb begin
    evt_set = '0;
    evt_set[`PBL_EVT_LOCK_CHG] = auto_q & (lock_d != lock_q);
    evt_set[`PBL_EVT_LOCK_LOSS] = auto_q & base_clock_select_q & lock_q & ~lock_d;
    evt_clr = wr_evt ? pwdata_i[`PBL_EVT_W-1:0] : '0;
    // set wins over a write-one-to-clear in the same cycle
    evt_d = (evt_q & ~evt_clr) | evt_set;
    if (!auto_q) begin
      evt_d = '0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      evt_q <= `PBL_EVT_RST;
    end else begin
      evt_q <= evt_d;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mask_q <= `PBL_MASK_RST;
    end else if (wr_mask) begin
      mask_q <= pwdata_i[`PBL_EVT_W-1:0];
    end
  end

  // enable bit gates the whole source; manual mode never interrupts
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= auto_q & pll_irq_enable_q & (|(evt_q & mask_q));
    end
  end

  assign prdata_o = rdata_q;
  assign pready_o = ready_q;
  assign pslverr_o = slverr_q;
  assign loop_filter_track_o = filt_q;
  assign pll_power_on_o = pll_power_on_q;
  assign base_clock_select_o = base_clock_select_q;
  assign lock_o = lock_q;
  assign irq_o = irq_q;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_lock_toggle;
    auto_q && (lock_d != lock_q);
  endsequence

  sequence s_irq_armed;
    auto_q && pll_irq_enable_q && mask_q[`PBL_EVT_LOCK_CHG];
  endsequence

  a_auto_track_set: assert property ((auto_run && acq_ok) |=> filt_q == pbl_pkg::PBL_TRACK)
    else $error("auto mode did not enter track inside the window");

  a_acq_read_only: assert property ((wr_ctrl && auto_q && wr_acq && !acq_ok) |=> filt_q == pbl_pkg::PBL_ACQUIRE)
    else $error("select bit written while automatic mode owns it");

  a_auto_track_clr: assert property ((auto_q && !acq_ok) |=> filt_q == pbl_pkg::PBL_ACQUIRE)
    else $error("auto mode stayed in track outside the window");

  a_lock_follows: assert property ((auto_run && lock_ok) ##1 (auto_run && lock_ok) |=> lock_o ##0 $stable(lock_o))
    else $error("lock output does not follow the lock window");

  a_lock_clears: assert property ((!auto_run || !lock_ok) |=> !lock_o)
    else $error("lock output stayed set outside the lock window");

  a_irq_needs_src: assert property (!(auto_q && pll_irq_enable_q && (|(evt_q & mask_q))) |=> !irq_o)
    else $error("interrupt raised with no armed pending event");

  a_lock_change_irq: assert property (s_lock_toggle ##1 s_irq_armed |=> irq_o)
    else $error("lock toggle raised no interrupt");

  a_manual_select: assert property ((wr_ctrl && !auto_q) |=> filt_q == $past(wr_acq))
    else $error("manual select bit write not applied to the filter");

  a_manual_no_irq: assert property (!auto_q |=> !irq_o ##0 !lock_o)
    else $error("manual mode produced lock or interrupt");

  a_manual_evt_clear: assert property ((!auto_q && !$past(auto_q)) |-> (evt_q == '0) ##1 (!irq_o))
    else $error("pending lock event kept in manual mode");

  // bus check assumes the master never raises penable without a setup cycle
  a_apb_answer: assert property ((psel_i && !penable_i && !ready_q) |=> ready_q ##1 !ready_q)
    else $error("apb answer not given in the first access cycle");

endmodule
`default_nettype wire

// ### tb/pbl_tb.sv
/*
 * Self-checking bench for the PLL bandwidth and lock control block.
 * Assumes the APB map and field layout of pbl_params.svh, one clock.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pbl_params.svh"

module tb;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [`PBL_ADDR_W-1:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic vco_in_acq_tol_i = 1'b0;
  logic vco_in_lock_tol_i = 1'b0;
  logic loop_filter_track_o;
  logic pll_power_on_o;
  logic base_clock_select_o;
  logic lock_o;
  logic irq_o;
  int fails = 0;
  int check_count = 0;
  logic [31:0] rdat;
  logic rerr;
  // software waits in the manual bring-up, plain defaults
  localparam int acq_wait_cyc = 20;
  localparam int lock_settle_cyc = 20;

  pbl_top u_dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .vco_in_acq_tol_i(vco_in_acq_tol_i),
    .vco_in_lock_tol_i(vco_in_lock_tol_i), .loop_filter_track_o(loop_filter_track_o),
    .pll_power_on_o(pll_power_on_o), .base_clock_select_o(base_clock_select_o),
    .lock_o(lock_o), .irq_o(irq_o)
  );

  initial begin
    forever #25 mclk_i = ~mclk_i;
  end

  task end_of_test;
    if (fails == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask

  // one idle edge first so psel never gets two assignments in one step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk_i);
      if (pready_o === 1'b1) break;
    end
    if (i == 20) begin
      fails++;
      end_of_test();
    end else begin
      rdat = prdata_o;
      rerr = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
    end
  endtask

  // one more edge so a check right after a write sees the new register state
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    @(posedge mclk_i);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask

  // sig: 0 filter mode, 1 lock, 2 irq
  task waitsig(input int sig, input logic val);
    int i;
    logic s;
    for (i = 0; i < 40; i++) begin
      @(posedge mclk_i);
      s = (sig == 0) ? loop_filter_track_o : (sig == 1) ? lock_o : irq_o;
      if (s === val) break;
    end
    chk({31'h0, s}, {31'h0, val});
    if (i == 40) end_of_test();
  endtask

  initial begin
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(`PBL_OFF_CTRL, 32'h00000001);
    rd(`PBL_OFF_STAT, 32'h00000000);
    rd(`PBL_OFF_EVT, 32'h00000000);
    rd(`PBL_OFF_MASK, 32'h00000000);
    rd(8'h10, 32'h00000000);
    chk({31'h0, rerr}, 32'h00000001);
    // auto mode: attempt to force track is ignored
    wr(`PBL_OFF_CTRL, 32'h00000017);
    rd(`PBL_OFF_CTRL, 32'h00000015);
    chk({30'h0, pll_power_on_o, loop_filter_track_o}, 32'h00000002);
    vco_in_acq_tol_i <= 1'b1;
    waitsig(0, 1'b1);
    rd(`PBL_OFF_STAT, 32'h00000006);
    vco_in_lock_tol_i <= 1'b1;
    waitsig(1, 1'b1);
    rd(`PBL_OFF_STAT, 32'h00000007);
    rd(`PBL_OFF_EVT, 32'h00000001);
    chk({31'h0, irq_o}, 32'h00000000);
    wr(`PBL_OFF_MASK, 32'h00000001);
    waitsig(2, 1'b1);
    wr(`PBL_OFF_EVT, 32'h00000001);
    repeat (2) @(posedge mclk_i);
    chk({31'h0, irq_o}, 32'h00000000);
    // lock loss while the vco drives the base clock
    wr(`PBL_OFF_CTRL, 32'h0000001D);
    chk({31'h0, base_clock_select_o}, 32'h00000001);
    wr(`PBL_OFF_MASK, 32'h00000003);
    vco_in_lock_tol_i <= 1'b0;
    waitsig(1, 1'b0);
    waitsig(2, 1'b1);
    rd(`PBL_OFF_EVT, 32'h00000003);
    wr(`PBL_OFF_EVT, 32'h00000003);
    vco_in_acq_tol_i <= 1'b0;
    waitsig(0, 1'b0);
    // manual mode: power the pll off, then on again with the select bit clear
    wr(`PBL_OFF_CTRL, 32'h00000010);
    chk({31'h0, pll_power_on_o}, 32'h00000000);
    vco_in_lock_tol_i <= 1'b1;
    vco_in_acq_tol_i <= 1'b1;
    wr(`PBL_OFF_CTRL, 32'h00000014);
    repeat (acq_wait_cyc) @(posedge mclk_i);
    chk({30'h0, lock_o, irq_o}, 32'h00000000);
    chk({31'h0, loop_filter_track_o}, 32'h00000000);
    rd(`PBL_OFF_STAT, 32'h00000004);
    rd(`PBL_OFF_EVT, 32'h00000000);
    wr(`PBL_OFF_CTRL, 32'h00000016);
    chk({31'h0, loop_filter_track_o}, 32'h00000001);
    rd(`PBL_OFF_CTRL, 32'h00000016);
    repeat (lock_settle_cyc) @(posedge mclk_i);
    wr(`PBL_OFF_CTRL, 32'h0000001E);
    chk({30'h0, base_clock_select_o, loop_filter_track_o}, 32'h00000003);
    wr(`PBL_OFF_CTRL, 32'h00000014);
    chk({31'h0, loop_filter_track_o}, 32'h00000000);
    // back to automatic: detector takes over again
    wr(`PBL_OFF_CTRL, 32'h00000015);
    waitsig(1, 1'b1);
    waitsig(0, 1'b1);
    waitsig(2, 1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
